// [src/lfo_level_and_tracking_gen.sv]
// Summary of operation
// - LFO waits after note start, then fades in; delay 01-99 slows the fade, delay 00 starts at full with no wait.
// - Trigger selects mono, poly, keyed mono or keyed poly.
// - Mono modes share one phase; poly modes give each voice its own phase and rate.
// - Keyed modes restart the LFO cycle at every new note.
// - Amplitude LFO acts only with nonzero depth or when routed in the matrix.
// - Output level starts from a base level 00-99.
// - Signed wheel depth -99..99 scales wheel into the level.
// - Signed aftertouch depth -99..99 scales aftertouch into the level.
// - Summed level is clamped so it never drops below zero.
// - Curve generator takes one selectable modulation source.
// - Eleven breakpoints 0-10, each programmable from 0 to 100.
// - Matrix gets a normal curve output and a stepped curve output.
// - Normal output ramps linearly between adjacent breakpoints.
// - Stepped output holds a breakpoint value until the next breakpoint is reached.
`timescale 1ns/1ps
`default_nettype none
module lfo_level_and_tracking_gen
    import lfo_pkg::*;
#(
    parameter int VOICES = 4
)(
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    input  wire lfo_pkg::lfo_cfg_t              cfg,
    input  wire lfo_pkg::lfo_ctl_t              ctl,
    input  wire logic [VOICES-1:0]              note_on,
    input  wire logic [VOICES-1:0]              gate,
    input  wire logic [7:0]                     rate [VOICES],
    input  wire logic [7:0]                     mod_src [lfo_pkg::NUM_SRC],
    input  wire logic [lfo_pkg::SRC_W-1:0]      track_sel,
    input  wire logic [7:0]                     point_val [lfo_pkg::NUM_POINTS],
    output logic [7:0]                          amplitude_osc_depth,
    output logic [7:0]                          lfo_level,
    output logic [VOICES-1:0][15:0]             lfo_phase,
    output logic [VOICES-1:0][7:0]              lfo_fade,
    output logic [VOICES-1:0]                   lfo_active,
    output logic [7:0]                          curve_map_source,
    output logic [7:0]                          stepped_curve_source
);
    import lfo_pkg::*;

    // Per-voice state sits in arrays; the limit keeps the voice loop to a practical size.
    // One voice is enough for the logic, though the bound checker watches the first two.
    if (VOICES < 1 || VOICES > 32)
    begin : g_voices_check
        $error("VOICES out of range");
    end

    // The fade counter must hold the longest wait, taken at the top delay setting.
    if (((int'(PARAM_MAX) + 1) * FADE_UNIT_CYC) / 64 >= (1 << FADE_CNT_W))
    begin : g_fade_cnt_check
        $error("fade counter too narrow");
    end

    // The raw reset may rise at any point in a cycle; two stages release the rest cleanly.
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    function automatic logic [7:0] clip99(input logic [7:0] v);
        clip99 = (v > PARAM_MAX) ? PARAM_MAX : v;
    endfunction

    // A larger delay stretches both the wait and each fade step, so it fades in more slowly.
    function automatic logic [FADE_CNT_W-1:0] fade_step_len(input logic [7:0] d);
        logic [FADE_CNT_W-1:0] t;
        t = FADE_CNT_W'(clip99(d)) + FADE_CNT_W'(1);
        fade_step_len = (t * FADE_CNT_W'(FADE_UNIT_CYC)) / FADE_CNT_W'(64);
    endfunction

    // Accumulators wrap freely at sixteen bits; only the increment differs from voice to voice.
    function automatic logic [15:0] phase_step(input logic [15:0] p, input logic [7:0] r);
        phase_step = p + {8'h00, r};
    endfunction

    // Signed depth times a 0..127 controller, scaled back to -99..99 range.
    function automatic logic signed [10:0] scale_ctl(input logic signed [7:0] d, input logic [7:0] c);
        logic signed [7:0]  dc;
        logic signed [16:0] p;
        dc = (d > 8'sh63) ? 8'sh63 : ((d < -8'sh63) ? -8'sh63 : d);
        p = 17'(dc) * 17'($signed({1'b0, c[6:0]}));
        scale_ctl = 11'(p >>> 7);
    endfunction

    // Level path.
    logic signed [10:0] lvl_sum;
    logic [7:0]         next_lfo_level;
    logic [7:0]         next_amp_depth;

    always_comb
    begin
        lvl_sum = $signed({3'b000, clip99(cfg.level)})
                + scale_ctl(cfg.wheel_depth, ctl.wheel)
                + scale_ctl(cfg.touch_depth, ctl.touch);
        if (lvl_sum < 0)
            next_lfo_level = 8'h00;
        // An eight-bit output cannot carry a sum above 255, so it saturates instead of wrapping.
        else if (lvl_sum > 11'sd255)
            next_lfo_level = 8'hff;
        else
            next_lfo_level = lvl_sum[7:0];
        // The depth to the amplitude stage is zero unless the depth is nonzero or the LFO is routed in the matrix.
        if (cfg.amp_depth != 8'h00 || cfg.matrix_routed)
            next_amp_depth = clip99(cfg.amp_depth);
        else
            next_amp_depth = 8'h00;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            lfo_level           <= LEVEL_RST;
            amplitude_osc_depth <= 8'h00;
        end
        else
        begin
            lfo_level           <= next_lfo_level;
            amplitude_osc_depth <= next_amp_depth;
        end
    end

    // Per-voice phase, delay and fade.
    lfo_state_t                    st [VOICES];
    lfo_state_t                    next_st [VOICES];
    logic [FADE_CNT_W-1:0]         cnt [VOICES];
    logic [FADE_CNT_W-1:0]         next_cnt [VOICES];
    logic [VOICES-1:0][15:0]       next_phase;
    logic [VOICES-1:0][7:0]        next_fade;
    logic [VOICES-1:0]             next_active;
    logic [15:0]                   shared_phase;
    logic [15:0]                   next_shared;
    logic                          is_mono;
    logic                          is_keyed;
    logic [FADE_CNT_W-1:0]         step_len;

    always_comb
    begin
        is_mono  = (cfg.trigger == LFO_TRIG_MONO) || (cfg.trigger == LFO_TRIG_KEY_MONO);
        is_keyed = (cfg.trigger == LFO_TRIG_KEY_MONO) || (cfg.trigger == LFO_TRIG_KEY_POLY);
        step_len = fade_step_len(cfg.delay);
        // Mono modes run one shared accumulator at the first voice's rate.
        next_shared = phase_step(shared_phase, rate[0]);
        if (is_keyed && (|note_on))
            next_shared = 16'h0000;
        for (int v = 0; v < VOICES; v++)
        begin
            next_st[v]     = st[v];
            next_cnt[v]    = cnt[v];
            next_fade[v]   = lfo_fade[v];
            next_active[v] = lfo_active[v];
            if (is_mono)
                next_phase[v] = next_shared;
            else if (is_keyed && note_on[v])
                next_phase[v] = 16'h0000;
            else
                next_phase[v] = phase_step(lfo_phase[v], rate[v]);
            // A note start wins over a released gate in the same cycle, so a retrigger is never lost.
            if (note_on[v])
            begin
                next_st[v]     = (cfg.delay == DELAY_RST) ? LFO_ST_FULL : LFO_ST_WAIT;
                next_cnt[v]    = '0;
                next_fade[v]   = (cfg.delay == DELAY_RST) ? FADE_FULL : 8'h00;
                next_active[v] = 1'b1;
            end
            else if (!gate[v])
            begin
                next_st[v]     = LFO_ST_IDLE;
                next_active[v] = 1'b0;
            end
            else
            begin
                unique case (st[v])
                    LFO_ST_IDLE: ;
                    LFO_ST_WAIT:
                    begin
                        if (cnt[v] >= step_len)
                        begin
                            next_st[v]  = LFO_ST_FADE;
                            next_cnt[v] = '0;
                        end
                        else
                            next_cnt[v] = cnt[v] + 20'h1;
                    end
                    // The fade climbs one count per step until it reaches full scale, then holds.
                    LFO_ST_FADE:
                    begin
                        if (cnt[v] >= (step_len >> 6))
                        begin
                            next_cnt[v]  = '0;
                            next_fade[v] = lfo_fade[v] + 8'h01;
                            if (lfo_fade[v] == 8'hfe)
                                next_st[v] = LFO_ST_FULL;
                        end
                        else
                            next_cnt[v] = cnt[v] + 20'h1;
                    end
                    LFO_ST_FULL:
                        next_fade[v] = FADE_FULL;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            shared_phase <= 16'h0000;
            lfo_phase    <= '0;
            lfo_fade     <= '0;
            lfo_active   <= '0;
            for (int v = 0; v < VOICES; v++)
            begin
                st[v]  <= LFO_ST_IDLE;
                cnt[v] <= '0;
            end
        end
        else
        begin
            shared_phase <= next_shared;
            lfo_phase    <= next_phase;
            lfo_fade     <= next_fade;
            lfo_active   <= next_active;
            for (int v = 0; v < VOICES; v++)
            begin
                st[v]  <= next_st[v];
                cnt[v] <= next_cnt[v];
            end
        end
    end

    // Curve generator. Input 0..255 maps to breakpoints every 25.5 counts;
    // scaling by 10/255 keeps 0 on point 0 and 255 exactly on point 10.
    logic [7:0]  trk_in;
    logic [11:0] scaled;
    logic [3:0]  seg;
    logic [7:0]  frac;
    logic [7:0]  pa;
    logic [7:0]  pb;
    logic [7:0]  next_curve;
    logic [7:0]  next_step;

    function automatic logic [7:0] clip100(input logic [7:0] v);
        clip100 = (v > POINT_MAX) ? POINT_MAX : v;
    endfunction

    // The fraction counts 256ths and the shift floors, so the result stays between the two points.
    function automatic logic [7:0] lerp(input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] f);
        logic signed [17:0] d;
        logic signed [17:0] r;
        d = $signed({10'h000, p1}) - $signed({10'h000, p0});
        r = $signed({10'h000, p0}) + ((d * $signed({10'h000, f})) >>> 8);
        lerp = r[7:0];
    endfunction

    always_comb
    begin
        trk_in = (track_sel < SRC_W'(NUM_SRC)) ? mod_src[track_sel] : 8'h00;
        scaled = 12'(({8'h00, trk_in} * 16'd160) / 16'd255);
        seg    = scaled[7:4];
        frac   = {scaled[3:0], 4'h0};
        if (seg >= 4'd10)
        begin
            seg  = 4'd10;
            frac = 8'h00;
        end
        pa = clip100(point_val[seg]);
        pb = (seg == 4'd10) ? pa : clip100(point_val[seg + 4'd1]);
        next_curve = lerp(pa, pb, frac);
        // The stepped output shows the point at or below the input and never looks ahead.
        next_step  = pa;
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            curve_map_source     <= 8'h00;
            stepped_curve_source <= 8'h00;
        end
        else
        begin
            curve_map_source     <= next_curve;
            stepped_curve_source <= next_step;
        end
    end

endmodule
`default_nettype wire

// [src/lfo_pkg.sv]
package lfo_pkg;

    localparam int VAL_W = 8;
    localparam int NUM_POINTS = 11;
    localparam int SRC_W = 5;
    localparam int NUM_SRC = 21;

    localparam logic [7:0] PARAM_MAX = 8'h63;
    localparam logic [7:0] POINT_MAX = 8'h64;
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic [7:0] DELAY_RST = 8'h00;

    // Fade-in: the delay value scales how many clock cycles pass per fade step.
    localparam int FADE_UNIT_US = 100;
    localparam int CLK_MHZ = 40;
    localparam int FADE_UNIT_CYC = FADE_UNIT_US * CLK_MHZ;
    localparam int FADE_CNT_W = 20;
    localparam logic [7:0] FADE_FULL = 8'hff;

    typedef enum logic [1:0] {
        LFO_TRIG_MONO     = 2'b00,
        LFO_TRIG_POLY     = 2'b01,
        LFO_TRIG_KEY_MONO = 2'b10,
        LFO_TRIG_KEY_POLY = 2'b11
    } lfo_trig_t;

    typedef enum logic [1:0] {
        LFO_ST_IDLE  = 2'b00,
        LFO_ST_WAIT  = 2'b01,
        LFO_ST_FADE  = 2'b10,
        LFO_ST_FULL  = 2'b11
    } lfo_state_t;

    typedef struct packed {
        logic [7:0]        level;
        logic signed [7:0] wheel_depth;
        logic signed [7:0] touch_depth;
        logic [7:0]        amp_depth;
        logic [7:0]        delay;
        lfo_trig_t         trigger;
        logic              matrix_routed;
    } lfo_cfg_t;

    typedef struct packed {
        logic [7:0] wheel;
        logic [7:0] touch;
    } lfo_ctl_t;

endpackage

// [verif/lfo_level_and_tracking_gen_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lfo_level_and_tracking_gen_assertions
    import lfo_pkg::*;
#(
    parameter int VOICES = 4
)(
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire lfo_pkg::lfo_cfg_t         cfg,
    input  wire logic [VOICES-1:0]         note_on,
    input  wire logic [7:0]                mod_src [lfo_pkg::NUM_SRC],
    input  wire logic [lfo_pkg::SRC_W-1:0] track_sel,
    input  wire logic [7:0]                point_val [lfo_pkg::NUM_POINTS],
    input  wire logic [7:0]                amplitude_osc_depth,
    input  wire logic [7:0]                lfo_level,
    input  wire logic [VOICES-1:0][15:0]   lfo_phase,
    input  wire logic [VOICES-1:0][7:0]    lfo_fade,
    input  wire logic [VOICES-1:0]         lfo_active,
    input  wire logic [7:0]                curve_map_source,
    input  wire logic [7:0]                stepped_curve_source
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Outputs lag the raw reset by two sync stages, so checks wait for them.
    logic [1:0] up;
    logic [1:0] next_up;
    logic       rdy, off, mid, nomod, quiet, bad_sel, full;
    always_comb
    begin
        next_up = (up == 2'h3) ? up : up + 2'h1;
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            up <= 2'h0;
        else
            up <= next_up;
    end
    assign rdy = up == 2'h3;
    assign off = cfg.amp_depth == 8'h00 && !cfg.matrix_routed;
    assign mid = cfg.amp_depth != 8'h00 && cfg.amp_depth <= PARAM_MAX;
    assign nomod = cfg.wheel_depth == 8'sh00 && cfg.touch_depth == 8'sh00 && cfg.level <= PARAM_MAX;
    assign quiet = cfg.level == 8'h00 && cfg.wheel_depth <= 0 && cfg.touch_depth <= 0;
    assign bad_sel = track_sel >= NUM_SRC && point_val[0] <= POINT_MAX;
    assign full = track_sel < NUM_SRC && mod_src[track_sel] == 8'hff && point_val[10] <= POINT_MAX;
    a_depth_gated: assert property (rdy && $past(off) |-> amplitude_osc_depth == 8'h00)
        else $error("depth output nonzero while unused");
    a_depth_passed: assert property (rdy && $past(mid) |-> amplitude_osc_depth == $past(cfg.amp_depth))
        else $error("depth output differs from setting");
    a_level_base: assert property (rdy && $past(nomod) |-> lfo_level == $past(cfg.level))
        else $error("level differs from base");
    a_level_floor: assert property (rdy && $past(quiet) |-> lfo_level == 8'h00)
        else $error("level above zero with nothing lifting it");
    a_bad_select: assert property (rdy && $past(bad_sel) |-> stepped_curve_source == $past(point_val[0]))
        else $error("unknown source not mapped to point zero");
    a_curve_top: assert property (rdy && $past(full) |-> curve_map_source == $past(point_val[10])
        && stepped_curve_source == $past(point_val[10]))
        else $error("full scale input not mapped to last point");
    a_fade_instant: assert property (rdy && note_on[0] && cfg.delay == 8'h00 |=>
        lfo_fade[0] == FADE_FULL && lfo_active[0])
        else $error("no instant fade with zero delay");
    a_fade_wait: assert property (rdy && note_on[0] && cfg.delay != 8'h00 |=> lfo_fade[0] == 8'h00)
        else $error("fade did not wait after note start");
    a_keyed_restart: assert property (rdy && note_on[0] && cfg.trigger[1] |=> lfo_phase[0] == 16'h0000)
        else $error("keyed mode did not restart phase");
    a_mono_shared: assert property ((rdy && !cfg.trigger[0] && lfo_active[1:0] == 2'b11) [*2] |->
        lfo_phase[0] == lfo_phase[1])
        else $error("mono voices out of phase");
    c_keyed: cover property (rdy && note_on[0] && cfg.trigger[1]);
    c_full: cover property (rdy && full);
    c_floor: cover property (rdy && quiet);
endmodule
bind lfo_level_and_tracking_gen lfo_level_and_tracking_gen_assertions #(.VOICES(VOICES)) u_chk (
    .ref_clk, .rst_n, .cfg, .note_on, .mod_src, .track_sel, .point_val, .amplitude_osc_depth, .lfo_level,
    .lfo_phase, .lfo_fade, .lfo_active, .curve_map_source, .stepped_curve_source);
`default_nettype wire

// [verif/lfo_mat_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side matrix slot: takes either the ramped or the stepped curve as its source.
module lfo_mat_model (
    input  wire logic       use_step,
    input  wire logic [7:0] curve_map_source,
    input  wire logic [7:0] stepped_curve_source,
    output logic [7:0]      track_mod
);
    always_comb
    begin
        track_mod = use_step ? stepped_curve_source : curve_map_source;
    end
endmodule
`default_nettype wire

// [verif/test_lfo_level_and_tracking_gen.sv]
`timescale 1ns/1ps
`default_nettype none
module test_lfo_level_and_tracking_gen;
    import lfo_pkg::*;
    logic             ref_clk = 1'b0;
    logic             rst_n, use_step;
    lfo_cfg_t         cfg;
    lfo_ctl_t         ctl;
    logic [3:0]       note_on, gate, active;
    logic [7:0]       rate [4];
    logic [7:0]       mod_src [NUM_SRC];
    logic [SRC_W-1:0] track_sel;
    logic [7:0]       point_val [NUM_POINTS];
    logic [7:0]       depth, level, crv, stp, track_mod;
    logic [3:0][15:0] phase;
    logic [3:0][7:0]  fade;
    int               seed = 32'hafa0;
    int               n_mismatch, n_checks, a, b, sc, e, cnt, last;
    int               dl [3] = '{0, 1, 99};
    always #12.5 ref_clk = ~ref_clk;
    lfo_level_and_tracking_gen #(.VOICES(4)) DUT (.ref_clk, .rst_n, .cfg, .ctl, .note_on, .gate, .rate,
        .mod_src, .track_sel, .point_val, .amplitude_osc_depth(depth), .lfo_level(level), .lfo_phase(phase),
        .lfo_fade(fade), .lfo_active(active), .curve_map_source(crv), .stepped_curve_source(stp));
    lfo_mat_model u_mat (.use_step, .curve_map_source(crv), .stepped_curve_source(stp), .track_mod);
    task automatic chk(input logic [7:0] got, input int lo_v, input int hi_v);
        n_checks++;
        if ((got >= 8'(lo_v) && got <= 8'(hi_v)) !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t got %0d want %0d..%0d", $time, got, lo_v, hi_v);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic int pt(input int k);
        return point_val[k] > POINT_MAX ? 100 : int'(point_val[k]);
    endfunction
    // Wheel and touch use only seven bits; the product is floored by the shift.
    function automatic int exp_level();
        int s;
        s = (cfg.level > PARAM_MAX ? 99 : int'(cfg.level))
            + ((int'(cfg.wheel_depth) * int'(ctl.wheel[6:0])) >>> 7)
            + ((int'(cfg.touch_depth) * int'(ctl.touch[6:0])) >>> 7);
        return s < 0 ? 0 : s;
    endfunction
    initial
    begin
        rst_n = 1'b0;
        cfg = '0;
        ctl = '0;
        note_on = '0;
        gate = '0;
        track_sel = '0;
        use_step = 1'b0;
        foreach (rate[k]) rate[k] = 8'(k * 16 + 5);
        foreach (mod_src[k]) mod_src[k] = 8'h00;
        foreach (point_val[k]) point_val[k] = 8'h00;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 400; i++)
        begin
            cfg.level = i % 7 ? 8'({$random(seed)} % 110) : 8'h00;
            cfg.wheel_depth = i % 11 ? 8'({$random(seed)} % 199 - 99) : 8'h00;
            cfg.touch_depth = i % 11 ? 8'({$random(seed)} % 199 - 99) : 8'h00;
            cfg.amp_depth = i % 4 ? 8'($random(seed)) : 8'h00;
            cfg.matrix_routed = i[1];
            ctl = 16'($random(seed));
            track_sel = 5'({$random(seed)} % 23);
            use_step = i[0];
            foreach (mod_src[k]) mod_src[k] = 8'($random(seed));
            foreach (point_val[k]) point_val[k] = 8'({$random(seed)} % 106);
            if (track_sel < NUM_SRC && i % 3 == 0)
                mod_src[track_sel] = i % 2 ? 8'hff : 8'h00;
            @(negedge ref_clk);
            e = exp_level();
            if (e < 256)
                chk(level, e, e);
            e = off_depth();
            chk(depth, e, e);
            sc = (track_sel < NUM_SRC ? int'(mod_src[track_sel]) : 0) * 160 / 255;
            a = pt(sc >> 4);
            b = (sc % 16 == 0) ? a : pt((sc >> 4) + 1);
            // Ramp in 256ths of a segment, floored, between the two neighbouring points.
            e = a + (((b - a) * (sc % 16) * 16) >>> 8);
            chk(stp, a, a);
            chk(crv, e, e);
            chk(track_mod, use_step ? a : e, use_step ? a : e);
        end
        for (int m = 0; m < 4; m++)
        begin
            cfg.trigger = lfo_trig_t'(m);
            gate = '0;
            @(negedge ref_clk);
            gate = '1;
            note_on = '1;
            @(negedge ref_clk);
            note_on = '0;
            chk(fade[0], 255, 255);
            chk(8'(active), 15, 15);
            repeat (20) @(negedge ref_clk);
            note_on = 4'h2;
            @(negedge ref_clk);
            note_on = '0;
            if (m > 1)
                chk(8'(phase[1] != 16'h0000), 0, 0);
            chk(8'(phase[0] != phase[1]), m % 2, m % 2);
        end
        cfg.trigger = LFO_TRIG_POLY;
        last = 0;
        foreach (dl[j])
        begin
            cfg.delay = 8'(dl[j]);
            gate = '0;
            @(negedge ref_clk);
            gate = '1;
            note_on = 4'h1;
            @(negedge ref_clk);
            note_on = '0;
            cnt = 1;
            while (fade[0] === 8'h00 && cnt < 10000)
            begin
                @(negedge ref_clk);
                cnt++;
            end
            chk(8'(cnt > last && cnt < 10000), 1, 1);
            last = cnt;
            if (cnt >= 10000)
                break;
        end
        finish_test();
    end
    function automatic int off_depth();
        if (cfg.amp_depth == 8'h00 && !cfg.matrix_routed)
            return 0;
        return cfg.amp_depth > PARAM_MAX ? 99 : int'(cfg.amp_depth);
    endfunction
endmodule
`default_nettype wire
